// ---- hw/spf_pkg.sv ----
package spf_pkg;

    // ----------------------------------------------------------------
    // Array geometry
    // ----------------------------------------------------------------
    localparam int          ADDR_W         = 18;
    localparam int          CNT_W          = 9;
    localparam int          PAGE_BYTES     = 256;
    localparam int          PAGES_PER_SECT = 256;
    localparam int          SECTORS        = 4;
    localparam int          PAGES          = SECTORS * PAGES_PER_SECT;
    localparam logic [8:0]  MAX_DATA       = 9'h100;
    localparam logic [9:0]  PROT_PAGES     = 10'h100;
    localparam logic [2:0]  HDR_BYTES      = 3'h4;

    // ----------------------------------------------------------------
    // Instruction codes
    // ----------------------------------------------------------------
    localparam logic [7:0]  CMD_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0]  CMD_WRITE_DISABLE = 8'h04;
    localparam logic [7:0]  CMD_READ_STATUS   = 8'h05;
    localparam logic [7:0]  CMD_PAGE_WRITE    = 8'h0a;
    localparam logic [7:0]  CMD_PAGE_PROGRAM  = 8'h02;
    localparam logic [7:0]  CMD_PAGE_ERASE    = 8'hdb;
    localparam logic [7:0]  CMD_SECTOR_ERASE  = 8'hd8;
    localparam logic [7:0]  CMD_DEEP_SLEEP    = 8'hb9;
    localparam logic [7:0]  CMD_WAKE          = 8'hab;

    // ----------------------------------------------------------------
    // Status byte layout and reset values
    // ----------------------------------------------------------------
    localparam int          STAT_BUSY_BIT  = 0;
    localparam int          STAT_WEL_BIT   = 1;
    localparam logic        WEL_RST        = 1'b0;
    localparam logic        SLEEP_RST      = 1'b0;
    localparam logic [4:0]  PIN_SYNC_RST   = 5'h1f;

    typedef enum logic [1:0] {
        KIND_PAGE_ERASE,
        KIND_SECT_ERASE,
        KIND_PROGRAM
    } spf_kind_t;

endpackage

// ---- hw/spf_sync.sv ----
`timescale 1ns/10ps
module spf_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         reset_n_in,
    // Asynchronous levels in, synchronised levels out
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_ff;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta_ff  <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end

endmodule

// ---- hw/spf_flash_if.sv ----
`timescale 1ns/10ps
// Functional notes
// - Output bits change after serial clock falls.
// - Input bits captured on serial clock rise.
// - Deselected means data output high impedance.
// - Standby only when deselected and not busy.
// - First chip select fall required before instructions.
// - Reset low while idle gives high-impedance reset.
// - Reset never aborts a running internal cycle.
// - Write protect low locks lowest 256 pages.
// - Both idle clock levels are supported.
// - Page write or program modifies 1-256 bytes.
// - Page write is erase then program.
// - Four sectors, 256 pages, 256 bytes each.
// - Page erase and sector erase both supported.
// - Write enable must precede each modify command.
// - Most significant bit first, opcode first.
// - Status holds busy bit0, latch bit1.
// - Latch clears on reset and command completion.
// - Deep sleep ignores all but wake command.
module spf_flash_if (
    // Clock and reset
    input  wire logic                      CLK_SYS_IN,
    input  wire logic                      RESET_N_IN,
    // Serial link pins
    input  wire logic                      SPI_CLK_IN,
    input  wire logic                      SPI_CS_N_IN,
    input  wire logic                      SPI_MOSI_IN,
    output logic                           SPI_MISO_OUT,
    output logic                           SPI_MISO_OE_OUT,
    input  wire logic                      HW_RESET_N_IN,
    input  wire logic                      WRITE_PROT_N_IN,
    // Page buffer fill
    output logic                           BUF_WR_OUT,
    output logic [7:0]                     BUF_IDX_OUT,
    output logic [7:0]                     BUF_DATA_OUT,
    // Internal cycle control towards the array
    output logic                           OP_START_OUT,
    output spf_pkg::spf_kind_t             OP_KIND_OUT,
    output logic [spf_pkg::ADDR_W-1:0]     OP_ADDR_OUT,
    output logic [spf_pkg::CNT_W-1:0]      OP_COUNT_OUT,
    input  wire logic                      OP_DONE_IN,
    // Power state
    output logic                           STANDBY_OUT,
    output logic                           SLEEP_OUT
);
    import spf_pkg::*;

    typedef enum logic [2:0] {S_IDLE, S_PAGE_ERASE, S_SECT_ERASE, S_PW_ERASE, S_PROGRAM} spf_op_st_t;

    logic                sclk_s, cs_n_s, mosi_s, hrst_n_s, wp_n_s;
    logic                sclk_prev_ff, cs_prev_ff;
    logic [2:0]          sync_ok_ff;
    logic                frame_ok_ff, sleep_ff, wel_ff, standby_ff;
    logic [2:0]          bit_cnt_ff, hdr_cnt_ff, out_cnt_ff;
    logic [7:0]          shift_ff, opcode_ff, out_shift_ff;
    logic [ADDR_W-1:0]   addr_ff;
    logic [CNT_W-1:0]    data_cnt_ff;
    logic                out_en_ff, miso_ff;
    spf_op_st_t          op_st_ff;
    logic                busy, in_reset, sclk_rise, sclk_fall, cs_fall, cs_rise;
    logic                byte_done, aligned, modify_ok, is_prot, cmd_go;
    logic [7:0]          nxt_shift, status_byte;

    // ------------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ------------------------------------------------------------------
    spf_sync #(.W(5), .RST_VAL(PIN_SYNC_RST)) u_pins (
        .clk_in     (CLK_SYS_IN),
        .reset_n_in (RESET_N_IN),
        .async_in   ({SPI_CLK_IN, SPI_CS_N_IN, SPI_MOSI_IN, HW_RESET_N_IN, WRITE_PROT_N_IN}),
        .sync_out   ({sclk_s, cs_n_s, mosi_s, hrst_n_s, wp_n_s})
    );

    // Pin history is trusted only once the synchronisers hold real samples, so a chip
    // select that is already low when reset ends never looks like a falling edge.
    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            sclk_prev_ff <= 1'b1;
            cs_prev_ff   <= 1'b1;
            sync_ok_ff   <= 3'h0;
        end else begin
            sclk_prev_ff <= sclk_s;
            cs_prev_ff   <= cs_n_s;
            sync_ok_ff   <= {sync_ok_ff[1:0], 1'b1};
        end
    end

    // Only edges seen inside a frame count, so the idle level is free.
    assign sclk_rise = sclk_s & ~sclk_prev_ff & ~cs_n_s & ~cs_prev_ff;
    assign sclk_fall = ~sclk_s & sclk_prev_ff & ~cs_n_s & ~cs_prev_ff;
    assign cs_fall   = cs_prev_ff & ~cs_n_s & sync_ok_ff[2];
    assign cs_rise   = ~cs_prev_ff & cs_n_s;
    assign busy      = (op_st_ff != S_IDLE);
    assign in_reset  = ~hrst_n_s & ~busy;
    assign nxt_shift = {shift_ff[6:0], mosi_s};
    assign byte_done = sclk_rise & frame_ok_ff & (bit_cnt_ff == 3'h7);
    assign aligned   = (bit_cnt_ff == 3'h0);
    assign status_byte = {6'h00, wel_ff, busy};

    // ------------------------------------------------------------------
    // Frame qualification
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            frame_ok_ff <= 1'b0;
        end else if (cs_rise || in_reset) begin
            frame_ok_ff <= 1'b0;
        end else if (cs_fall) begin
            frame_ok_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Input shifting: opcode, three address bytes, then data
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            bit_cnt_ff  <= 3'h0;
            hdr_cnt_ff  <= 3'h0;
            shift_ff    <= 8'h00;
            opcode_ff   <= 8'h00;
            addr_ff     <= '0;
            data_cnt_ff <= '0;
        end else if (cs_fall) begin
            bit_cnt_ff  <= 3'h0;
            hdr_cnt_ff  <= 3'h0;
            data_cnt_ff <= '0;
        end else if (sclk_rise && frame_ok_ff) begin
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            shift_ff   <= nxt_shift;
            if (byte_done) begin
                if (hdr_cnt_ff == 3'h0) begin
                    opcode_ff <= nxt_shift;
                end else if (hdr_cnt_ff != HDR_BYTES) begin
                    addr_ff <= {addr_ff[ADDR_W-9:0], nxt_shift};
                end else if (data_cnt_ff != MAX_DATA) begin
                    data_cnt_ff <= data_cnt_ff + 9'h001;
                end
                if (hdr_cnt_ff != HDR_BYTES) begin
                    hdr_cnt_ff <= hdr_cnt_ff + 3'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Page buffer fill, wrapping inside the addressed page
    // ------------------------------------------------------------------
    assign modify_ok = wel_ff & ~busy & ~sleep_ff;
    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            BUF_WR_OUT   <= 1'b0;
            BUF_IDX_OUT  <= 8'h00;
            BUF_DATA_OUT <= 8'h00;
        end else begin
            BUF_WR_OUT <= byte_done && hdr_cnt_ff == HDR_BYTES && modify_ok &&
                          (opcode_ff == CMD_PAGE_WRITE || opcode_ff == CMD_PAGE_PROGRAM);
            if (byte_done) begin
                BUF_IDX_OUT  <= addr_ff[7:0] + data_cnt_ff[7:0];
                BUF_DATA_OUT <= nxt_shift;
            end
        end
    end

    // ------------------------------------------------------------------
    // Status read: serial output changes on falling clock edges
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            out_en_ff    <= 1'b0;
            out_cnt_ff   <= 3'h0;
            out_shift_ff <= 8'h00;
            miso_ff      <= 1'b0;
        end else if (cs_n_s || in_reset) begin
            out_en_ff  <= 1'b0;
            out_cnt_ff <= 3'h0;
        end else begin
            if (byte_done && hdr_cnt_ff == 3'h0 && nxt_shift == CMD_READ_STATUS && !sleep_ff) begin
                out_en_ff <= 1'b1;
            end
            if (sclk_fall && out_en_ff) begin
                out_cnt_ff <= out_cnt_ff + 3'h1;
                if (out_cnt_ff == 3'h0) begin
                    miso_ff      <= status_byte[7];
                    out_shift_ff <= {status_byte[6:0], 1'b0};
                end else begin
                    miso_ff      <= out_shift_ff[7];
                    out_shift_ff <= {out_shift_ff[6:0], 1'b0};
                end
            end
        end
    end

    assign SPI_MISO_OUT    = miso_ff;
    assign SPI_MISO_OE_OUT = ~cs_n_s & out_en_ff & ~in_reset;

    // ------------------------------------------------------------------
    // Instruction execution at the end of a frame
    // ------------------------------------------------------------------
    assign is_prot = ~wp_n_s & (addr_ff[ADDR_W-1:8] < PROT_PAGES);
    assign cmd_go  = cs_rise && frame_ok_ff && aligned && modify_ok && !is_prot &&
                     hdr_cnt_ff == HDR_BYTES && hrst_n_s &&
                     (((opcode_ff == CMD_PAGE_WRITE || opcode_ff == CMD_PAGE_PROGRAM) && data_cnt_ff != '0) ||
                      ((opcode_ff == CMD_PAGE_ERASE || opcode_ff == CMD_SECTOR_ERASE) && data_cnt_ff == '0));

    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            wel_ff   <= WEL_RST;
            sleep_ff <= SLEEP_RST;
        end else if (!hrst_n_s) begin
            wel_ff <= WEL_RST;
            if (!busy) begin
                sleep_ff <= SLEEP_RST;
            end
        end else begin
            if (op_st_ff != S_IDLE && op_st_ff != S_PW_ERASE && OP_DONE_IN) begin
                wel_ff <= 1'b0;
            end
            if (cs_rise && frame_ok_ff && aligned && hdr_cnt_ff == 3'h1 && !busy) begin
                if (sleep_ff) begin
                    if (opcode_ff == CMD_WAKE) begin
                        sleep_ff <= 1'b0;
                    end
                end else begin
                    unique case (opcode_ff)
                        CMD_WRITE_ENABLE:  wel_ff <= 1'b1;
                        CMD_WRITE_DISABLE: wel_ff <= 1'b0;
                        CMD_DEEP_SLEEP:    sleep_ff <= 1'b1;
                        default: ;
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Internal cycle sequencing towards the array
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            op_st_ff     <= S_IDLE;
            OP_START_OUT <= 1'b0;
            OP_KIND_OUT  <= KIND_PAGE_ERASE;
            OP_ADDR_OUT  <= '0;
            OP_COUNT_OUT <= '0;
        end else begin
            OP_START_OUT <= 1'b0;
            unique case (op_st_ff)
                S_IDLE: begin
                    if (cmd_go) begin
                        OP_START_OUT <= 1'b1;
                        OP_ADDR_OUT  <= addr_ff;
                        OP_COUNT_OUT <= data_cnt_ff;
                        unique case (opcode_ff)
                            CMD_PAGE_WRITE: begin
                                op_st_ff    <= S_PW_ERASE;
                                OP_KIND_OUT <= KIND_PAGE_ERASE;
                            end
                            CMD_PAGE_PROGRAM: begin
                                op_st_ff    <= S_PROGRAM;
                                OP_KIND_OUT <= KIND_PROGRAM;
                            end
                            CMD_SECTOR_ERASE: begin
                                op_st_ff    <= S_SECT_ERASE;
                                OP_KIND_OUT <= KIND_SECT_ERASE;
                            end
                            default: begin
                                op_st_ff    <= S_PAGE_ERASE;
                                OP_KIND_OUT <= KIND_PAGE_ERASE;
                            end
                        endcase
                    end
                end
                S_PW_ERASE: begin
                    if (OP_DONE_IN) begin
                        op_st_ff     <= S_PROGRAM;
                        OP_START_OUT <= 1'b1;
                        OP_KIND_OUT  <= KIND_PROGRAM;
                    end
                end
                S_PAGE_ERASE, S_SECT_ERASE, S_PROGRAM: begin
                    if (OP_DONE_IN) begin
                        op_st_ff <= S_IDLE;
                    end
                end
                default: op_st_ff <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            standby_ff <= 1'b1;
        end else begin
            standby_ff <= cs_n_s & ~busy;
        end
    end

    assign STANDBY_OUT = standby_ff;
    assign SLEEP_OUT   = sleep_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RESET_N_IN);

    chk_miso_after_fall: assert property ($changed(miso_ff) |-> $past(sclk_fall))
        else $error("serial output changed without a falling clock edge");
    chk_bit_capture: assert property (sclk_rise && frame_ok_ff |=> bit_cnt_ff == $past(bit_cnt_ff) + 3'h1)
        else $error("bit not captured on rising clock edge");
    chk_hiz_deselect: assert property (cs_n_s |-> !SPI_MISO_OE_OUT)
        else $error("output driven while deselected");
    chk_standby_busy: assert property (busy |=> !STANDBY_OUT)
        else $error("standby entered while busy");
    chk_frame_arm: assert property ($rose(frame_ok_ff) |-> $past(cs_fall))
        else $error("frame armed without chip select fall");
    chk_reset_hiz: assert property (in_reset |-> !SPI_MISO_OE_OUT ##1 !frame_ok_ff)
        else $error("reset mode left output or frame live");
    chk_busy_holds: assert property (busy && !hrst_n_s && !OP_DONE_IN |=> busy)
        else $error("reset aborted an internal cycle");
    chk_protect_low: assert property (OP_START_OUT && !$past(wp_n_s) && $past(op_st_ff) == S_IDLE
                                      |-> OP_ADDR_OUT[ADDR_W-1:8] >= PROT_PAGES)
        else $error("protected page modified");
    chk_count_range: assert property (OP_START_OUT && OP_KIND_OUT == KIND_PROGRAM
                                      |-> OP_COUNT_OUT >= 9'h001 && OP_COUNT_OUT <= MAX_DATA)
        else $error("program byte count out of range");
    chk_pw_sequence: assert property (op_st_ff == S_PW_ERASE && OP_DONE_IN
                                      |=> OP_START_OUT && OP_KIND_OUT == KIND_PROGRAM)
        else $error("page write did not follow erase with program");
    chk_wel_needed: assert property (cmd_go |-> wel_ff ##1 OP_START_OUT)
        else $error("modify started without write enable");
    chk_wel_clear: assert property (op_st_ff == S_PROGRAM && OP_DONE_IN |=> !wel_ff && !busy)
        else $error("latch not cleared at completion");
    chk_sleep_ignore: assert property (sleep_ff && cs_rise && opcode_ff != CMD_WAKE && hrst_n_s |=> sleep_ff)
        else $error("deep sleep left by a non-wake command");
    chk_status_top: assert property (sclk_fall && out_en_ff && out_cnt_ff == 3'h0 |=> miso_ff == 1'b0)
        else $error("status upper bits not zero");

    cov_page_write: cover property (op_st_ff == S_PW_ERASE ##[1:1000] op_st_ff == S_PROGRAM);
    cov_sect_erase: cover property (OP_START_OUT && OP_KIND_OUT == KIND_SECT_ERASE);
    cov_status_read: cover property (SPI_MISO_OE_OUT && busy);
    cov_sleep_wake: cover property ($fell(sleep_ff));

endmodule

// ---- verif/spf_spi_master.sv ----
`timescale 1ns/10ps
module spf_spi_master (
    // Clock reference and returned data
    input  wire logic clk_in,
    input  wire logic miso_in,
    // Serial link drive
    output logic      sck_out,
    output logic      cs_n_out,
    output logic      mosi_out
);
    logic [7:0] tx[$];
    logic [7:0] rx;
    logic       cpol = 1'b0;

    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end

    // ----------------------------------------------------------------
    // One framed transfer of the queued bytes plus extra stray bits.
    // ----------------------------------------------------------------
    task automatic frame(input int extra);
        int n;
        n = tx.size() * 8 + extra;
        @(negedge clk_in);
        sck_out = cpol;
        cs_n_out = 1'b0;
        #200;
        for (int i = 0; i < n; i++) begin
            sck_out = 1'b0;
            mosi_out = (i / 8 < tx.size()) ? tx[i/8][7-i%8] : 1'b1;
            #200;
            rx = {rx[6:0], miso_in};
            sck_out = 1'b1;
            #200;
        end
        sck_out = cpol;
        #200;
        cs_n_out = 1'b1;
        mosi_out = ~mosi_out;
        #300;
    endtask
endmodule

// ---- verif/spf_flash_if_tb_top.sv ----
`timescale 1ns/10ps
module spf_flash_if_tb_top;
    import spf_pkg::*;

    // ----------------------------------------------------------------
    // Pins and bookkeeping
    // ----------------------------------------------------------------
    logic        clk = 1'b0;
    logic        rst_n;
    logic        hw_rst_n;
    logic        wp_n;
    logic        done;
    logic        sck;
    logic        cs_n;
    logic        mosi;
    logic        miso;
    logic        oe;
    wire         miso_wire = oe ? miso : 1'bz;
    logic        bwr;
    logic [7:0]  bidx;
    logic [7:0]  bdat;
    logic        start;
    spf_kind_t   kind;
    logic [17:0] addr;
    logic [8:0]  cnt;
    logic        stby;
    logic        slp;
    int          n_fail = 0;
    int          total_checks = 0;
    int          n_starts = 0;
    int          n_used = 0;
    logic [15:0] bq[$];

    spf_flash_if i_spf_flash_if (.CLK_SYS_IN(clk), .RESET_N_IN(rst_n), .SPI_CLK_IN(sck),
        .SPI_CS_N_IN(cs_n), .SPI_MOSI_IN(mosi), .SPI_MISO_OUT(miso), .SPI_MISO_OE_OUT(oe),
        .HW_RESET_N_IN(hw_rst_n), .WRITE_PROT_N_IN(wp_n), .BUF_WR_OUT(bwr), .BUF_IDX_OUT(bidx),
        .BUF_DATA_OUT(bdat), .OP_START_OUT(start), .OP_KIND_OUT(kind), .OP_ADDR_OUT(addr),
        .OP_COUNT_OUT(cnt), .OP_DONE_IN(done), .STANDBY_OUT(stby), .SLEEP_OUT(slp));
    spf_spi_master i_spf_spi_master (.clk_in(clk), .miso_in(miso_wire), .sck_out(sck),
        .cs_n_out(cs_n), .mosi_out(mosi));

    always #25 clk = ~clk;
    always @(posedge clk) begin
        if (start === 1'b1) n_starts <= n_starts + 1;
        if (bwr === 1'b1) bq.push_back({bidx, bdat});
    end

    // ----------------------------------------------------------------
    // Shared helpers
    // ----------------------------------------------------------------
    task automatic report_and_stop();
        if (n_fail == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic send(input logic [7:0] op);
        i_spf_spi_master.tx = '{op};
        i_spf_spi_master.frame(0);
    endtask

    task automatic status(input logic [7:0] exp);
        i_spf_spi_master.tx = '{CMD_READ_STATUS, 8'h00};
        i_spf_spi_master.frame(0);
        chk(i_spf_spi_master.rx, exp);
        chk(oe, 1'b0);
    endtask

    task automatic wait_start(input spf_kind_t k, input logic [17:0] a, input logic [8:0] c);
        int i;
        // The start pulse is over before the frame task returns, so count pulses.
        for (i = 0; i < 40 && n_starts == n_used; i++) @(negedge clk);
        if (i == 40) begin
            n_fail++;
            report_and_stop();
        end
        n_used++;
        chk({kind, addr, cnt}, {k, a, c});
    endtask

    task automatic finish_op();
        @(negedge clk) done = 1'b1;
        @(negedge clk) done = 1'b0;
    endtask

    task automatic no_start(input int extra);
        int s;
        s = n_starts;
        i_spf_spi_master.frame(extra);
        repeat (20) @(negedge clk);
        chk(n_starts, s);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_and_arm();
        chk({stby, slp, oe}, 3'b100);
        send(CMD_WRITE_ENABLE);
        status(8'h00);
    endtask

    task automatic t_latch_mode0();
        send(CMD_WRITE_ENABLE);
        status(8'h02);
        send(CMD_WRITE_DISABLE);
        status(8'h00);
    endtask

    task automatic t_page_write_mode3();
        i_spf_spi_master.cpol = 1'b1;
        send(CMD_WRITE_ENABLE);
        i_spf_spi_master.tx = '{CMD_PAGE_WRITE, 8'hf3, 8'h12, 8'hfe, 8'ha5, 8'h3c};
        i_spf_spi_master.frame(0);
        chk({bq.size(), bq[0], bq[1]}, {32'd2, 16'hfea5, 16'hff3c});
        wait_start(KIND_PAGE_ERASE, 18'h312fe, 9'h002);
        status(8'h03);
        chk(stby, 1'b0);
        finish_op();
        wait_start(KIND_PROGRAM, 18'h312fe, 9'h002);
        finish_op();
        repeat (5) @(negedge clk);
        chk(stby, 1'b1);
        status(8'h00);
        i_spf_spi_master.cpol = 1'b0;
    endtask

    task automatic t_protect();
        @(negedge clk) wp_n = 1'b0;
        send(CMD_WRITE_ENABLE);
        i_spf_spi_master.tx = '{CMD_PAGE_ERASE, 8'h00, 8'hff, 8'h00};
        no_start(0);
        status(8'h02);
        i_spf_spi_master.tx = '{CMD_SECTOR_ERASE, 8'h01, 8'h00, 8'h00};
        i_spf_spi_master.frame(0);
        wait_start(KIND_SECT_ERASE, 18'h10000, 9'h000);
        finish_op();
        @(negedge clk) wp_n = 1'b1;
        send(CMD_WRITE_ENABLE);
        i_spf_spi_master.tx = '{CMD_PAGE_ERASE, 8'h00, 8'hff, 8'h00};
        i_spf_spi_master.frame(0);
        wait_start(KIND_PAGE_ERASE, 18'h0ff00, 9'h000);
        finish_op();
    endtask

    task automatic t_refused();
        repeat (5) @(negedge clk);
        i_spf_spi_master.tx = '{CMD_PAGE_PROGRAM, 8'h02, 8'h00, 8'h00, 8'h11};
        no_start(0);
        send(CMD_WRITE_ENABLE);
        i_spf_spi_master.tx = '{CMD_PAGE_PROGRAM, 8'h02, 8'h00, 8'h00, 8'h11};
        no_start(1);
    endtask

    task automatic t_sleep();
        send(CMD_WRITE_DISABLE);
        send(CMD_DEEP_SLEEP);
        chk(slp, 1'b1);
        send(CMD_WRITE_ENABLE);
        send(CMD_WAKE);
        chk(slp, 1'b0);
        status(8'h00);
    endtask

    task automatic t_hw_reset();
        send(CMD_WRITE_ENABLE);
        i_spf_spi_master.tx = '{CMD_SECTOR_ERASE, 8'h02, 8'h00, 8'h00};
        i_spf_spi_master.frame(0);
        wait_start(KIND_SECT_ERASE, 18'h20000, 9'h000);
        @(negedge clk) hw_rst_n = 1'b0;
        repeat (10) @(negedge clk);
        chk(stby, 1'b0);
        finish_op();
        repeat (5) @(negedge clk);
        chk(stby, 1'b1);
        status(8'hzz);
        @(negedge clk) hw_rst_n = 1'b1;
        repeat (5) @(negedge clk);
        status(8'h00);
    endtask

    initial begin
        rst_n = 1'b0;
        hw_rst_n = 1'b1;
        wp_n = 1'b1;
        done = 1'b0;
        #1 i_spf_spi_master.cs_n_out = 1'b0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        t_reset_and_arm();
        t_latch_mode0();
        t_page_write_mode3();
        t_protect();
        t_refused();
        t_sleep();
        t_hw_reset();
        report_and_stop();
    end
endmodule
